// ---- verilog/cd_overlay_timer.sv ----
// Three-channel down-counter overlaid on the parallel group zero offsets
`timescale 1ns/100ps
//
// Contract
// R01: Three independent 16-bit down counters, count up to 65,535.
// R02: Any write at offset 0xD maps counters into offsets 0 to 3.
// R03: A read at offset 0xD maps counters out, parallel group back in.
// R04: Overlay switching never resets or alters counters; they keep running.
// R05: Mode 0: output low on load, high at zero, gate enables counting.
// R06: Mode 1: gate edge drives output low, high at zero, retriggerable.
// R07: Mode 2: divide by N, one-clock low pulse, reload, gate low stops.
// R08: Mode 3: square wave, decrement by two, odd N splits (N+1)/2,(N-1)/2.
// R09: Mode 4: count on write, one-clock low at zero, reload to repeat.
// R10: Mode 5: gate edge starts count, one-clock low at terminal, retrigger.
// R11: Positive clock pulse is one count; gate rising edge is a trigger.
// R12: Control byte: select 7:6, access 5:4, mode 3:1, decimal flag 0.
// R13: Select 0,1,2 picks a counter; select 3 is read-back command.
// R14: Access 00 latch, 01 low byte, 10 high byte, 11 low then high.
// R15: Mode codes per table; top bit ignored for modes 2 and 3.
// R16: Decimal flag 0 counts binary, 1 counts binary-coded decimal.
// R17: Wiring allows event counting and chaining two counters as 32 bits.
// R18: Latch copies count into a hold register; reads return held value.
// R19: Host performs low/high access in pairs to keep byte flip-flop aligned.
// R20: Mapped in, offsets 0,1,2 reach counters, offset 3 takes control.
module cd_overlay_timer (
  input  wire logic           clk,          // 250 MHz system clock
  input  wire logic           sys_rst,      // Synchronous reset
  input  wire cd_pkg::cd_io_s io_req,       // Host I/O strobe, addr, data
  input  wire logic [2:0]     cnt_clk_pin,  // Channel count inputs
  input  wire logic [2:0]     cnt_gate_pin, // Channel gate inputs
  input  wire logic           chain_en_pin, // Chain channel 1 on output 0
  output logic [7:0]          io_rdata,     // Read data, registered
  output logic [2:0]          cnt_out,      // Channel outputs
  output logic                parallel_port_group_zero_sel // Group 0 mapped
);
  import cd_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [2:0] clk_rise;
  logic [2:0] gate_lvl;
  logic [2:0] gate_rise;
  logic       chain_lvl;

  for (genvar i = 0; i < CD_NCH; i++) begin : g_pin
    cd_sync u_clk (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pin     (cnt_clk_pin[i]),
      .level   (),
      .rise    (clk_rise[i])
    );
    cd_sync u_gate (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pin     (cnt_gate_pin[i]),
      .level   (gate_lvl[i]),
      .rise    (gate_rise[i])
    );
  end

  cd_sync u_chain (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     (chain_en_pin),
    .level   (chain_lvl),
    .rise    ()
  );

  // ==========================================================
  // Host decode
  cd_ctrl_s   cw;
  logic       mapped_reg, mapped_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       ppsel_reg, ppsel_next;
  logic       bank_hit;
  logic       ctrl_wr;
  logic [1:0] sel;
  logic [1:0] acc;
  logic [2:0] mode_new;
  logic [2:0] ch_wr, ch_rd, ch_prog, ch_latch, ch_stlat;
  logic [7:0] ch_rbyte [CD_NCH];

  assign cw       = io_req.data;
  assign bank_hit = mapped_reg && (io_req.addr[3:2] == CD_OFS_BANK); // R20
  assign ctrl_wr  = bank_hit && io_req.wr
                    && (io_req.addr == CD_OFS_CTRL); // R20
  assign sel = {cw.counter_select_high, cw.counter_select_low}; // R12
  assign acc = {cw.access_order_high, cw.access_order_low}; // R12
  // Top mode bit ignored for rate and square modes
  assign mode_new = cw.operating_mode_bit1
    ? {1'b0, cw.operating_mode_bit1, cw.operating_mode_bit0}
    : {cw.operating_mode_bit2, 1'b0, cw.operating_mode_bit0}; // R15

  for (genvar i = 0; i < CD_NCH; i++) begin : g_dec
    assign ch_wr[i] = bank_hit && io_req.wr
                      && (io_req.addr[1:0] == 2'(i)); // R20
    assign ch_rd[i] = bank_hit && io_req.rd
                      && (io_req.addr[1:0] == 2'(i)); // R20
    assign ch_prog[i] = ctrl_wr && (sel == 2'(i))
                        && (acc != CD_ACC_LATCH); // R13
    assign ch_latch[i] = ctrl_wr && (((sel == 2'(i))
                         && (acc == CD_ACC_LATCH)) // R14
                         || ((sel == CD_SEL_RB) && !io_req.data[CD_RB_CNT]
                         && io_req.data[CD_RB_CH0 + i])); // R13
    assign ch_stlat[i] = ctrl_wr && (sel == CD_SEL_RB)
                         && !io_req.data[CD_RB_STA]
                         && io_req.data[CD_RB_CH0 + i]; // R13
  end

  // Overlay touches only the decode, never channel state
  always_comb begin
    mapped_next = mapped_reg;
    if (io_req.wr && io_req.addr == CD_OFS_OVL) begin
      mapped_next = 1'b1; // R02
    end else if (io_req.rd && io_req.addr == CD_OFS_OVL) begin
      mapped_next = 1'b0; // R03 R04
    end
    ppsel_next = ~mapped_next;
    rdata_next = rdata_reg;
    if (io_req.rd) begin
      rdata_next = CD_RDATA_RST;
      for (int i = 0; i < CD_NCH; i++) begin
        if (ch_rd[i]) begin
          rdata_next = ch_rbyte[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mapped_reg <= CD_MAP_RST;
      ppsel_reg  <= ~CD_MAP_RST;
      rdata_reg  <= CD_RDATA_RST;
    end else begin
      mapped_reg <= mapped_next;
      ppsel_reg  <= ppsel_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign io_rdata = rdata_reg;
  assign parallel_port_group_zero_sel = ppsel_reg;

  // ==========================================================
  // Counter channels
  cd_chan_s [2:0] chan_reg;
  cd_chan_s [2:0] chan_next;
  logic     [2:0] tick;

  // Channel 1 may count rising edges of output 0
  assign tick[0] = clk_rise[0]; // R11
  assign tick[1] = chain_lvl ? (chan_next[0].out & ~chan_reg[0].out)
                             : clk_rise[1]; // R17
  assign tick[2] = clk_rise[2]; // R11

  for (genvar i = 0; i < CD_NCH; i++) begin : g_ch
    cd_chan_s    c;
    logic [15:0] dec_val;
    logic [15:0] src;
    logic [15:0] val;
    logic        step2;
    logic        run_en;
    logic        term3;
    logic        ld;

    assign c      = chan_reg[i];
    assign step2  = (c.mode == CD_M3) && !(c.count[0] && c.out); // R08
    assign src    = c.cnt_held ? c.hold : c.count; // R18
    assign run_en = gate_lvl[i] || c.mode == CD_M1 || c.mode == CD_M5;
    assign term3  = (dec_val == 16'h0000)
                    || (dec_val == 16'h0001 && !c.out); // R08

    cd_dec u_dec (
      .value  (c.count),
      .bcd    (c.bcd),
      .step2  (step2),
      .result (dec_val)
    ); // R16

    always_comb begin
      if (c.sta_held) begin
        ch_rbyte[i] = c.stat;
      end else if (c.acc == CD_ACC_HI
                   || (c.acc == CD_ACC_LOHI && c.rd_hi)) begin
        ch_rbyte[i] = src[15:8]; // R14
      end else begin
        ch_rbyte[i] = src[7:0]; // R14
      end
    end

    always_comb begin
      chan_next[i] = c;
      ld  = 1'b0;
      val = c.reload;
      // Host read side effects
      if (ch_rd[i]) begin
        if (c.sta_held) begin
          chan_next[i].sta_held = 1'b0;
        end else if (c.acc == CD_ACC_LOHI) begin
          chan_next[i].rd_hi = !c.rd_hi; // R19
          if (c.rd_hi) begin
            chan_next[i].cnt_held = 1'b0; // R18
          end
        end else begin
          chan_next[i].cnt_held = 1'b0; // R18
        end
      end
      // Second latch ignored until the hold is read
      if (ch_latch[i] && !c.cnt_held) begin
        chan_next[i].cnt_held = 1'b1; // R18
        chan_next[i].hold     = c.count; // R18
      end
      if (ch_stlat[i] && !c.sta_held) begin
        chan_next[i].sta_held = 1'b1;
        chan_next[i].stat = {c.out, c.null_cnt, c.acc, c.mode, c.bcd};
      end
      if (ch_prog[i]) begin
        chan_next[i].mode      = mode_new; // R15
        chan_next[i].acc       = acc; // R14
        chan_next[i].bcd       = cw.bcd; // R16
        chan_next[i].out       = (mode_new != CD_M0); // R05
        chan_next[i].run       = 1'b0;
        chan_next[i].have      = 1'b0;
        chan_next[i].null_cnt  = 1'b1;
        chan_next[i].wr_hi     = 1'b0;
        chan_next[i].rd_hi     = 1'b0;
        chan_next[i].load_pend = 1'b0;
        chan_next[i].trig_pend = 1'b0;
        chan_next[i].cnt_held  = 1'b0;
        chan_next[i].sta_held  = 1'b0;
      end else if (ch_wr[i]) begin
        unique case (c.acc)
          CD_ACC_LO: begin
            ld  = 1'b1;
            val = {8'h00, io_req.data}; // R14
          end
          CD_ACC_HI: begin
            ld  = 1'b1;
            val = {io_req.data, 8'h00}; // R14
          end
          default: begin
            chan_next[i].wr_hi = !c.wr_hi; // R19
            if (!c.wr_hi) begin
              chan_next[i].lo_tmp = io_req.data;
            end else begin
              ld  = 1'b1;
              val = {io_req.data, c.lo_tmp}; // R14
            end
          end
        endcase
        if (ld) begin
          chan_next[i].reload    = val; // R01
          chan_next[i].load_pend = 1'b1;
          chan_next[i].have      = 1'b1;
          chan_next[i].null_cnt  = 1'b1;
          if (c.mode == CD_M0) begin
            chan_next[i].out = 1'b0; // R05
          end
        end
      end else if (tick[i]) begin
        chan_next[i].trig_pend = 1'b0;
        if (c.load_pend && (c.mode == CD_M0 || c.mode == CD_M4
            || ((c.mode == CD_M2 || c.mode == CD_M3) && !c.run))) begin
          chan_next[i].count     = c.reload; // R09
          chan_next[i].run       = 1'b1;
          chan_next[i].load_pend = 1'b0;
          chan_next[i].null_cnt  = 1'b0;
          chan_next[i].out       = (c.mode != CD_M0);
        end else if (c.trig_pend && c.have && c.mode != CD_M0
                     && c.mode != CD_M4) begin
          chan_next[i].count     = c.reload; // R06 R10
          chan_next[i].run       = 1'b1;
          chan_next[i].load_pend = 1'b0;
          chan_next[i].null_cnt  = 1'b0;
          chan_next[i].out       = (c.mode != CD_M1); // R06
        end else if (c.run && run_en) begin
          unique case (c.mode)
            CD_M0: begin
              chan_next[i].count = dec_val;
              if (dec_val == 16'h0000) begin
                chan_next[i].out = 1'b1; // R05
              end
            end
            CD_M1: begin
              chan_next[i].count = dec_val;
              if (dec_val == 16'h0000) begin
                chan_next[i].out = 1'b1; // R06
                chan_next[i].run = 1'b0;
              end
            end
            CD_M2: begin
              if (c.count == 16'h0001) begin
                chan_next[i].count     = c.reload; // R07
                chan_next[i].out       = 1'b1;
                chan_next[i].load_pend = 1'b0;
                chan_next[i].null_cnt  = 1'b0;
              end else begin
                chan_next[i].count = dec_val;
                if (dec_val == 16'h0001) begin
                  chan_next[i].out = 1'b0; // R07
                end
              end
            end
            CD_M3: begin
              if (term3) begin
                chan_next[i].count     = c.reload; // R08
                chan_next[i].out       = !c.out; // R08
                chan_next[i].load_pend = 1'b0;
                chan_next[i].null_cnt  = 1'b0;
              end else begin
                chan_next[i].count = dec_val; // R08
              end
            end
            CD_M4, CD_M5: begin
              if (!c.out) begin
                chan_next[i].out = 1'b1; // R09 R10
                chan_next[i].run = 1'b0; // R09
              end else begin
                chan_next[i].count = dec_val;
                if (dec_val == 16'h0000) begin
                  chan_next[i].out = 1'b0; // R09 R10
                end
              end
            end
          endcase
        end
      end
      // Gate low forces rate and square outputs high
      if (!gate_lvl[i] && (c.mode == CD_M2 || c.mode == CD_M3)) begin
        chan_next[i].out = 1'b1; // R07
      end
      if (gate_rise[i]) begin
        chan_next[i].trig_pend = 1'b1; // R11
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        chan_reg[i] <= CD_CHAN_RST;
      end else begin
        chan_reg[i] <= chan_next[i]; // R04
      end
    end

    assign cnt_out[i] = chan_reg[i].out;
  end

endmodule // cd_overlay_timer

// ---- include/cd_pkg.sv ----
// Package: constants and carriers for the overlaid three-channel timer
package cd_pkg;

  // ==========================================================
  // Host offsets
  localparam logic [3:0] CD_OFS_CTRL = 4'h3;
  localparam logic [3:0] CD_OFS_OVL  = 4'hD;
  localparam logic [1:0] CD_OFS_BANK = 2'h0;
  localparam int         CD_NCH      = 3;

  // ==========================================================
  // Control byte fields
  localparam logic [1:0] CD_SEL_RB    = 2'h3;
  localparam logic [1:0] CD_ACC_LATCH = 2'h0;
  localparam logic [1:0] CD_ACC_LO    = 2'h1;
  localparam logic [1:0] CD_ACC_HI    = 2'h2;
  localparam logic [1:0] CD_ACC_LOHI  = 2'h3;
  localparam int         CD_RB_CNT    = 5;
  localparam int         CD_RB_STA    = 4;
  localparam int         CD_RB_CH0    = 1;

  // ==========================================================
  // Mode codes after normalisation
  localparam logic [2:0] CD_M0 = 3'h0;
  localparam logic [2:0] CD_M1 = 3'h1;
  localparam logic [2:0] CD_M2 = 3'h2;
  localparam logic [2:0] CD_M3 = 3'h3;
  localparam logic [2:0] CD_M4 = 3'h4;
  localparam logic [2:0] CD_M5 = 3'h5;

  // ==========================================================
  // Reset values
  localparam logic       CD_MAP_RST   = 1'b0;
  localparam logic [7:0] CD_RDATA_RST = 8'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic counter_select_high;
    logic counter_select_low;
    logic access_order_high;
    logic access_order_low;
    logic operating_mode_bit2;
    logic operating_mode_bit1;
    logic operating_mode_bit0;
    logic bcd;
  } cd_ctrl_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] data;
  } cd_io_s;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] hold;
    logic [7:0]  stat;
    logic [7:0]  lo_tmp;
    logic [2:0]  mode;
    logic [1:0]  acc;
    logic        bcd;
    logic        out;
    logic        run;
    logic        have;
    logic        null_cnt;
    logic        cnt_held;
    logic        sta_held;
    logic        wr_hi;
    logic        rd_hi;
    logic        load_pend;
    logic        trig_pend;
  } cd_chan_s;

  localparam cd_chan_s CD_CHAN_RST = '{out: 1'b1, acc: CD_ACC_LOHI,
                                       default: '0};

endpackage

// ---- verilog/cd_sync.sv ----
// Two-stage pin synchroniser with rising-edge detect
`timescale 1ns/100ps
module cd_sync (
  input  wire logic clk,     // System clock
  input  wire logic sys_rst, // Synchronous reset
  input  wire logic pin,     // Asynchronous pin
  output logic      level,   // Synchronised level
  output logic      rise     // One-cycle rising edge
);
  logic meta_reg, sync_reg, prev_reg;
  logic meta_next, sync_next, prev_next;

  always_comb begin
    meta_next = pin;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
endmodule // cd_sync

// ---- verilog/cd_dec.sv ----
// Binary or decimal decrement by one or two
`timescale 1ns/100ps
module cd_dec (
  input  wire logic [15:0] value,  // Present count
  input  wire logic        bcd,    // Decimal counting
  input  wire logic        step2,  // Subtract two
  output logic [15:0]      result  // Decremented count
);
  logic [4:0]  brw;
  logic [15:0] dres;
  logic [15:0] bres;

  assign brw[0] = 1'b0;
  assign bres   = value - (step2 ? 16'h0002 : 16'h0001);

  // Digit-wise subtract with borrow ripple
  for (genvar k = 0; k < 4; k++) begin : g_dig
    logic [3:0] sub;
    logic [4:0] diff;
    assign sub  = (k == 0) ? {2'h0, step2, ~step2} : {3'h0, brw[k]};
    assign diff = {1'b0, value[4*k +: 4]} - {1'b0, sub};
    assign brw[k+1] = diff[4];
    assign dres[4*k +: 4] = diff[4] ? diff[3:0] + 4'hA : diff[3:0];
  end

  assign result = bcd ? dres : bres;
endmodule // cd_dec

// ---- dv/cd_overlay_timer_sva.sv ----
// Port assertions for the overlaid three-channel timer
`timescale 1ns/100ps
module cd_overlay_timer_sva
  import cd_pkg::*;
(
  input logic           clk,                          // Clock
  input logic           sys_rst,                      // Reset
  input cd_pkg::cd_io_s io_req,                       // Host request
  input logic [2:0]     cnt_clk_pin,                  // Count inputs
  input logic [2:0]     cnt_gate_pin,                 // Gate inputs
  input logic           chain_en_pin,                 // Chain strap
  input logic [7:0]     io_rdata,                     // Read data
  input logic [2:0]     cnt_out,                      // Outputs
  input logic           parallel_port_group_zero_sel  // Group 0 mapped
);
  // ==========
  // Setup
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire sel = parallel_port_group_zero_sel;
  wire ovl = (io_req.rd | io_req.wr) && io_req.addr == CD_OFS_OVL;

  // ==========
  // Properties
  property p_map_in;
    io_req.wr && io_req.addr == CD_OFS_OVL |=> !sel;
  endproperty
  a_map_in: assert property (p_map_in) else $error("map in missing");
  property p_map_out;
    io_req.rd && io_req.addr == CD_OFS_OVL |=> sel && io_rdata == 8'h00;
  endproperty
  a_map_out: assert property (p_map_out) else $error("map out bad");
  property p_sel_hold;
    !ovl |=> $stable(sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("map moved");
  property p_rd_out;
    io_req.rd && io_req.addr[3:2] == CD_OFS_BANK && sel |=> io_rdata == 8'h00;
  endproperty
  a_rd_out: assert property (p_rd_out) else $error("counter leaked");
  property p_rd_unmapped;
    io_req.rd && io_req.addr[3:2] != 2'h0 && !ovl |=> io_rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("nonzero");
  property p_rdata_hold;
    !io_req.rd |=> $stable(io_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rd moved");
  property p_m0_low;
    (io_req.wr && io_req.addr == CD_OFS_CTRL && io_req.data == 8'h10 && !sel)
      ##2 (io_req.wr && io_req.addr == 4'h0) |=> !cnt_out[0];
  endproperty
  a_m0_low: assert property (p_m0_low) else $error("mode 0 not low");
  property p_m4_high;
    (io_req.wr && io_req.addr == CD_OFS_CTRL && io_req.data == 8'h58 && !sel)
      ##2 (io_req.wr && io_req.addr == 4'h1) |=> cnt_out[1];
  endproperty
  a_m4_high: assert property (p_m4_high) else $error("mode 4 not high");
endmodule // cd_overlay_timer_sva

bind cd_overlay_timer cd_overlay_timer_sva u_sva (
  .clk(clk), .sys_rst(sys_rst), .io_req(io_req),
  .cnt_clk_pin(cnt_clk_pin), .cnt_gate_pin(cnt_gate_pin),
  .chain_en_pin(chain_en_pin), .io_rdata(io_rdata), .cnt_out(cnt_out),
  .parallel_port_group_zero_sel(parallel_port_group_zero_sel));

// ---- dv/cd_host_model.sv ----
// Host bus model issuing one-cycle I/O strobes
`timescale 1ns/100ps
module cd_host_model (
  input  logic           clk,      // Clock
  input  logic [7:0]     io_rdata, // Read data
  output cd_pkg::cd_io_s io_req    // Host request
);
  import cd_pkg::*;
  // ==========
  // Bus cycles
  initial io_req = '0;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{rd: 1'h0, wr: 1'h1, addr: a, data: d};
    @(posedge clk);
    io_req.wr <= 1'h0;
    io_req.data <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    io_req <= '{rd: 1'h1, wr: 1'h0, addr: a, data: 8'h00};
    @(posedge clk);
    io_req.rd <= 1'h0;
    @(posedge clk);
    d = io_rdata;
  endtask
  // Low byte then high byte
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask
endmodule // cd_host_model

// ---- dv/tb.sv ----
// Self-checking bench for the overlaid timer
`timescale 1ns/100ps
module tb;
  import cd_pkg::*;
  logic       clk = 1'h0;
  logic       sys_rst = 1'h1;
  logic [2:0] cnt_clk_pin = 3'h0;
  logic [2:0] cnt_gate_pin = 3'h0;
  logic       chain_en_pin = 1'h0;
  cd_io_s     io_req;
  logic [7:0] io_rdata;
  logic [2:0] cnt_out;
  logic       sel;
  logic [7:0] d;
  int         bad_count = 0;
  int         num_checks = 0;
  // Control byte, count, output after ticks one to six
  localparam logic [21:0] rows [6] = '{
    {8'h10, 8'h03, 6'h07}, {8'h12, 8'h02, 6'h0F}, {8'h14, 8'h03, 6'h36},
    {8'h16, 8'h04, 6'h33}, {8'h18, 8'h02, 6'h37}, {8'h1A, 8'h02, 6'h37}};

  always #2 clk = ~clk;

  cd_overlay_timer dut (
    .clk(clk), .sys_rst(sys_rst), .io_req(io_req),
    .cnt_clk_pin(cnt_clk_pin), .cnt_gate_pin(cnt_gate_pin),
    .chain_en_pin(chain_en_pin), .io_rdata(io_rdata), .cnt_out(cnt_out),
    .parallel_port_group_zero_sel(sel));
  cd_host_model host (.clk(clk), .io_rdata(io_rdata), .io_req(io_req));

  // ==========
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int c);
    @(posedge clk);
    cnt_clk_pin[c] <= 1'h1;
    repeat (6) @(posedge clk);
    cnt_clk_pin[c] <= 1'h0;
    repeat (6) @(posedge clk);
  endtask
  task automatic gate(input int c, input logic v);
    @(posedge clk);
    cnt_gate_pin[c] <= v;
    repeat (6) @(posedge clk);
  endtask

  // ==========
  // Sequence
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    @(posedge clk);
    chk({7'h00, sel}, 8'h01);
    chk(io_rdata, 8'h00);
    chk({5'h00, cnt_out}, 8'h07);
    host.rd(4'h0, d);
    chk(d, 8'h00);
    host.wr(CD_OFS_OVL, 8'h5A);
    @(posedge clk);
    chk({7'h00, sel}, 8'h00);
    host.wr(4'h5, 8'hFF);
    host.rd(4'h5, d);
    chk(d, 8'h00);
    chk({7'h00, sel}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      gate(0, 1'h0);
      host.wr(CD_OFS_CTRL, rows[i][21:14]);
      host.wr(4'h0, rows[i][13:6]);
      gate(0, 1'h1);
      for (int t = 5; t >= 0; t--) begin
        tick(0);
        chk(8'(cnt_out[0]), 8'(rows[i][t]));
      end
    end
    host.wr(CD_OFS_CTRL, 8'h58);
    host.wr(4'h1, 8'h03);
    @(posedge clk);
    chk({7'h00, cnt_out[1]}, 8'h01);
    gate(1, 1'h1);
    repeat (4) tick(1);
    chk({7'h00, cnt_out[1]}, 8'h00);
    host.wr(CD_OFS_CTRL, 8'hBD);
    host.wr16(4'h2, 16'h0010);
    gate(2, 1'h1);
    tick(2);
    tick(2);
    host.wr(CD_OFS_CTRL, 8'h80);
    host.rd(CD_OFS_OVL, d);
    chk(d, 8'h00);
    chk({7'h00, sel}, 8'h01);
    tick(2);
    tick(2);
    host.rd(4'h2, d);
    chk(d, 8'h00);
    host.wr(CD_OFS_OVL, 8'h00);
    host.rd(4'h2, d);
    chk(d, 8'h09);
    host.rd(4'h2, d);
    chk(d, 8'h00);
    host.rd(4'h2, d);
    chk(d, 8'h07);
    host.rd(4'h2, d);
    chk(d, 8'h00);
    host.wr(CD_OFS_CTRL, 8'hE8);
    host.rd(4'h2, d);
    chk(d, 8'hB5);
    host.wr(CD_OFS_CTRL, 8'hD8);
    tick(2);
    host.rd(4'h2, d);
    chk(d, 8'h07);
    host.rd(4'h2, d);
    chk(d, 8'h00);
    // High byte only access
    host.wr(CD_OFS_CTRL, 8'hA0);
    host.wr(4'h2, 8'h01);
    tick(2);
    host.rd(4'h2, d);
    chk(d, 8'h01);
    // Largest count
    host.wr(CD_OFS_CTRL, 8'hB0);
    host.wr16(4'h2, 16'hFFFF);
    tick(2);
    host.rd(4'h2, d);
    chk(d, 8'hFF);
    host.rd(4'h2, d);
    chk(d, 8'hFF);
    // Channel 1 counts rises of output 0
    chain_en_pin <= 1'h1;
    host.wr(CD_OFS_CTRL, 8'h50);
    host.wr(4'h1, 8'h02);
    host.wr(CD_OFS_CTRL, 8'h14);
    host.wr(4'h0, 8'h02);
    repeat (6) tick(0);
    chk({7'h00, cnt_out[1]}, 8'h00);
    tick(0);
    chk({7'h00, cnt_out[1]}, 8'h01);
    // Reset in mid-run
    sys_rst <= 1'h1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    @(posedge clk);
    chk({7'h00, sel}, 8'h01);
    chk(io_rdata, 8'h00);
    chk({5'h00, cnt_out}, 8'h07);
    end_of_test();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule // tb
